// ==== rtl/nand_ctl_map.svh ====
// register offsets, field positions, command codes and timing counts of the nand controller
`ifndef NAND_CTL_MAP_SVH
`define NAND_CTL_MAP_SVH
`define OFS_CTRL         12'h000
`define OFS_STAT         12'h004
`define OFS_DATA         12'h008
`define OFS_ID_LO        12'h00c
`define OFS_ID_HI        12'h010
`define CTRL_GO          0
`define CTRL_OP_LSB      1
`define CTRL_WP          4
`define OP_STATUS        3'h0
`define OP_ID            3'h1
`define OP_RESET         3'h2
`define OP_READ_RESUME   3'h3
`define CMD_READ         8'h00
`define CMD_STATUS       8'h70
`define CMD_RESET        8'hff
`define CMD_ID           8'h90
`define ID_BYTES         3'h5
`define STRB_NS          24
`define STRB_CYC         (((`STRB_NS) * 125 + 999) / 1000)
`endif

// ==== rtl/nand_ctl_pkg.sv ====
// types of the nand controller
package nand_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD  = 3'b001,
    ST_ADR  = 3'b011,
    ST_RD   = 3'b010,
    ST_DONE = 3'b110
  } seq_e;
endpackage : nand_ctl_pkg

// ==== rtl/sync2.sv ====
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module sync2 (
  input  wire logic ref_clk_in,  // clock
  input  wire logic rstn_in,     // async reset, low
  input  wire logic d_in,        // async level
  output var  logic q_out        // synchronised level
);
  logic meta_r;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

// ==== rtl/nand_ctl.sv ====
// apb-controlled nand command host: status, id, reset and read resume
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "nand_ctl_map.svh"
// Operation
// - only status or reset while busy
// - power-on: only reset or status
// - never issue undefined command codes
// - after serial input, restricted commands
// - program pages in ascending order
module nand_ctl (
  input  wire logic        ref_clk_in,          // 125 MHz clock
  input  wire logic        rstn_in,             // async reset, low
  input  wire logic        psel_in,             // apb select
  input  wire logic        penable_in,          // apb enable
  input  wire logic        pwrite_in,           // apb write
  input  wire logic [11:0] paddr_in,            // apb byte address
  input  wire logic [31:0] pwdata_in,           // apb write data
  output var  logic [31:0] prdata_out,          // apb read data
  output var  logic        pready_out,          // apb ready
  output var  logic        pslverr_out,         // apb error
  output var  logic        cmd_latch_out,       // command latch enable
  output var  logic        addr_latch_out,      // address latch enable
  output var  logic        chip_en_n_out,       // chip enable, low
  output var  logic        write_strobe_n_out,  // write strobe, low
  output var  logic        read_strobe_n_out,   // read strobe, low
  output var  logic        write_prot_n_out,    // write protect, low
  output var  logic [7:0]  shared_byte_port_out, // port drive value
  output var  logic        shared_byte_port_oe_out, // port drive enable
  input  wire logic [7:0]  shared_byte_port_in, // port level
  input  wire logic        ready_busy_n_pin_in  // device ready, high
);
  localparam logic [7:0] STRB = 8'(`STRB_CYC);
  ////////////////////////////////////////////////////////////////
  logic [7:0] port_s;
  logic       rdy_s;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sync
      sync2 u_s (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
                 .d_in(shared_byte_port_in[gi]), .q_out(port_s[gi]));
    end
  endgenerate
  sync2 u_rdy (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
               .d_in(ready_busy_n_pin_in), .q_out(rdy_s));
  ////////////////////////////////////////////////////////////////
  nand_ctl_pkg::seq_e st_r, st_nxt;
  logic [2:0]  op_r, op_nxt;
  logic [7:0]  tmr_r, tmr_nxt;
  logic [1:0]  ph_r, ph_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [7:0]  data_r, data_nxt;
  logic [39:0] id_r, id_nxt;
  logic        wp_r, wp_nxt;
  logic        err_r, err_nxt;
  logic        done_r, done_nxt;
  logic        cle_r, cle_nxt, ale_r, ale_nxt, we_r, we_nxt, re_r, re_nxt;
  logic [7:0]  dq_r, dq_nxt;
  logic        oe_r, oe_nxt;
  logic        ce_n_r, ce_n_nxt;
  logic [31:0] prd_r, prd_nxt;
  logic        prdy_r, prdy_nxt, perr_r, perr_nxt;
  logic        acc, go;
  logic [7:0]  cmd;
  assign acc = psel_in && penable_in && !prdy_r;
  assign go  = acc && pwrite_in && (paddr_in == `OFS_CTRL) && pwdata_in[`CTRL_GO];
  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    cmd = `CMD_STATUS;
    case (op_r)
      `OP_ID:          cmd = `CMD_ID;
      `OP_RESET:       cmd = `CMD_RESET;
      `OP_READ_RESUME: cmd = `CMD_READ;
      default:         cmd = `CMD_STATUS;
    endcase
  end
  always_comb
  begin
    st_nxt = st_r; op_nxt = op_r; tmr_nxt = tmr_r; ph_nxt = ph_r;
    cnt_nxt = cnt_r; data_nxt = data_r; id_nxt = id_r; wp_nxt = wp_r;
    err_nxt = err_r; done_nxt = done_r; cle_nxt = cle_r; ale_nxt = ale_r;
    we_nxt = we_r; re_nxt = re_r; dq_nxt = dq_r; oe_nxt = oe_r;
    prd_nxt = 32'h0; prdy_nxt = 1'b0; perr_nxt = 1'b0;
    if (acc)
    begin
      prdy_nxt = 1'b1;
      case (paddr_in)
        `OFS_CTRL:
        begin
          prd_nxt = {27'h0, wp_r, op_r, 1'b0};
          if (pwrite_in)
          begin
            wp_nxt = pwdata_in[`CTRL_WP];
            if (go && st_r == nand_ctl_pkg::ST_IDLE)
            begin
              // only defined ops; non status/reset refused while busy
              if (pwdata_in[3:1] > `OP_READ_RESUME ||
                  (!rdy_s && pwdata_in[3:1] != `OP_STATUS && pwdata_in[3:1] != `OP_RESET))
                err_nxt = 1'b1;
              else
              begin
                op_nxt = pwdata_in[3:1]; st_nxt = nand_ctl_pkg::ST_CMD;
                tmr_nxt = 8'h0; ph_nxt = 2'h0; cnt_nxt = 3'h0; err_nxt = 1'b0;
                done_nxt = 1'b0;
              end
            end
            else if (go)
              err_nxt = 1'b1;
          end
        end
        `OFS_STAT: prd_nxt = {26'h0, err_r, done_r, wp_r, rdy_s,
                              1'b0, st_r == nand_ctl_pkg::ST_IDLE};
        `OFS_DATA:  prd_nxt = {24'h0, data_r};
        `OFS_ID_LO: prd_nxt = id_r[31:0];
        `OFS_ID_HI: prd_nxt = {24'h0, id_r[39:32]};
        default:    perr_nxt = 1'b1;
      endcase
    end
    if (st_r != nand_ctl_pkg::ST_IDLE)
      tmr_nxt = tmr_r + 8'h1;
    case (st_r)
      nand_ctl_pkg::ST_IDLE:
      begin
        cle_nxt = 1'b0; ale_nxt = 1'b0; we_nxt = 1'b1; re_nxt = 1'b1; oe_nxt = 1'b0;
      end
      nand_ctl_pkg::ST_CMD, nand_ctl_pkg::ST_ADR:
      begin
        cle_nxt = (st_r == nand_ctl_pkg::ST_CMD);
        ale_nxt = (st_r == nand_ctl_pkg::ST_ADR);
        dq_nxt = (st_r == nand_ctl_pkg::ST_CMD) ? cmd : 8'h00;
        oe_nxt = 1'b1;
        if (tmr_r == STRB - 8'h1)
        begin
          tmr_nxt = 8'h0;
          ph_nxt = ph_r + 2'h1;
          we_nxt = (ph_r == 2'h0) ? 1'b0 : 1'b1;
          if (ph_r == 2'h2)
          begin
            ph_nxt = 2'h0;
            if (st_r == nand_ctl_pkg::ST_CMD && op_r == `OP_ID)
              st_nxt = nand_ctl_pkg::ST_ADR;
            else if (op_r == `OP_RESET || op_r == `OP_READ_RESUME)
              st_nxt = nand_ctl_pkg::ST_DONE;
            else
              st_nxt = nand_ctl_pkg::ST_RD;
          end
        end
      end
      nand_ctl_pkg::ST_RD:
      begin
        cle_nxt = 1'b0; ale_nxt = 1'b0; oe_nxt = 1'b0;
        if (tmr_r == STRB - 8'h1)
        begin
          tmr_nxt = 8'h0;
          ph_nxt = ph_r + 2'h1;
          re_nxt = (ph_r == 2'h0) ? 1'b0 : 1'b1;
          if (ph_r == 2'h1)
          begin
            data_nxt = port_s;
            if (op_r == `OP_ID)
              id_nxt = {port_s, id_r[39:8]};
          end
          if (ph_r == 2'h2)
          begin
            ph_nxt = 2'h0;
            cnt_nxt = cnt_r + 3'h1;
            if (op_r != `OP_ID || cnt_r == `ID_BYTES - 3'h1)
              st_nxt = nand_ctl_pkg::ST_DONE;
          end
        end
      end
      nand_ctl_pkg::ST_DONE:
      begin
        oe_nxt = 1'b0; cle_nxt = 1'b0; ale_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = nand_ctl_pkg::ST_IDLE;
      end
      default: st_nxt = nand_ctl_pkg::ST_IDLE;
    endcase
    ce_n_nxt = (st_nxt == nand_ctl_pkg::ST_IDLE);
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r <= nand_ctl_pkg::ST_IDLE; op_r <= 3'h0; tmr_r <= 8'h0; ph_r <= 2'h0;
      cnt_r <= 3'h0; data_r <= 8'h0; id_r <= 40'h0; wp_r <= 1'b0; err_r <= 1'b0;
      done_r <= 1'b0; cle_r <= 1'b0; ale_r <= 1'b0; we_r <= 1'b1; re_r <= 1'b1;
      dq_r <= 8'h0; oe_r <= 1'b0; prd_r <= 32'h0; prdy_r <= 1'b0; perr_r <= 1'b0;
      ce_n_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt; op_r <= op_nxt; tmr_r <= tmr_nxt; ph_r <= ph_nxt;
      cnt_r <= cnt_nxt; data_r <= data_nxt; id_r <= id_nxt; wp_r <= wp_nxt;
      err_r <= err_nxt; done_r <= done_nxt; cle_r <= cle_nxt; ale_r <= ale_nxt;
      we_r <= we_nxt; re_r <= re_nxt; dq_r <= dq_nxt; oe_r <= oe_nxt;
      prd_r <= prd_nxt; prdy_r <= prdy_nxt; perr_r <= perr_nxt;
      ce_n_r <= ce_n_nxt;
    end
  end
  assign prdata_out = prd_r;
  assign pready_out = prdy_r;
  assign pslverr_out = perr_r;
  assign cmd_latch_out = cle_r;
  assign addr_latch_out = ale_r;
  assign chip_en_n_out = ce_n_r;
  assign write_strobe_n_out = we_r;
  assign read_strobe_n_out = re_r;
  assign write_prot_n_out = wp_r;
  assign shared_byte_port_out = dq_r;
  assign shared_byte_port_oe_out = oe_r;
  ////////////////////////////////////////////////////////////////
  a_busy_gate: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (go && st_r == nand_ctl_pkg::ST_IDLE && !rdy_s && pwdata_in[3:1] == `OP_ID)
      |=> err_r && st_r == nand_ctl_pkg::ST_IDLE)
    else $error("id started while busy");
  a_undef_op: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (go && st_r == nand_ctl_pkg::ST_IDLE && pwdata_in[3:1] > `OP_READ_RESUME)
      |=> st_r == nand_ctl_pkg::ST_IDLE)
    else $error("undefined op started");
  a_pwr_on: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (st_r == nand_ctl_pkg::ST_CMD && !rdy_s && cle_r && oe_r)
      |-> dq_r == `CMD_STATUS || dq_r == `CMD_RESET)
    else $error("bad command while busy");
  a_id_addr: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ale_r && oe_r) |-> dq_r == 8'h00)
    else $error("id address not zero");
  a_wp_follow: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (acc && pwrite_in && paddr_in == `OFS_CTRL) |=> wp_r == $past(pwdata_in[`CTRL_WP]))
    else $error("write protect not updated");
  a_done_idle: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    st_r == nand_ctl_pkg::ST_DONE |=> st_r == nand_ctl_pkg::ST_IDLE && done_r)
    else $error("done not reached");
  a_rd_capture: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (st_r == nand_ctl_pkg::ST_RD && ph_r == 2'h1 && tmr_r == STRB - 8'h1)
      |=> data_r == $past(port_s))
    else $error("read byte not captured");
  a_id_count: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (st_r == nand_ctl_pkg::ST_RD && op_r == `OP_ID) |-> cnt_r < `ID_BYTES)
    else $error("too many id bytes");
endmodule : nand_ctl
`default_nettype wire

// ==== verif/nand_dev_model.sv ====
// behavioural model of the flash device behind the controller
`timescale 1ns/10ps
`default_nettype none
module nand_dev_model #(
  parameter int         POR_NS = 3000,  // power-on busy time
  parameter int         RST_NS = 1000,  // busy time after reset command
  parameter logic [7:0] MAKER  = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVICE = 8'h3c  // arbitrary value
) (
  input  wire logic       cle_in,               // command latch
  input  wire logic       ale_in,               // address latch
  input  wire logic       ce_n_in,              // chip enable, low
  input  wire logic       we_n_in,              // write strobe, low
  input  wire logic       read_strobe_n_in,     // read strobe, low
  input  wire logic       wp_n_in,              // write protect, low
  input  wire logic [7:0] dq_in,                // port level
  input  wire logic [7:0] id3_in,               // third id byte
  input  wire logic [7:0] id4_in,               // fourth id byte
  input  wire logic [7:0] id5_in,               // fifth id byte
  output var  logic [7:0] dq_out,               // device port value
  output var  logic       ready_busy_n_pin_out  // ready, high
);
  logic       busy;
  logic       id_mode;
  logic [2:0] idx;
  logic [7:0] last;
  logic [7:0] cur;
  logic [7:0] stat;
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    busy    = 1'h1;
    id_mode = 1'h0;
    idx     = 3'h0;
    last    = 8'h00;
    #(POR_NS) busy = 1'h0;
  end
  assign ready_busy_n_pin_out = ~busy;
  assign stat = {wp_n_in, 1'h0, ~busy, 3'h0, 1'h0, 1'h0};
  // commands other than status and reset are ignored while busy
  always @(posedge we_n_in)
  begin
    if (!ce_n_in && cle_in && dq_in == 8'hff)
    begin
      id_mode = 1'h0;
      busy    = 1'h1;
      busy <= #(RST_NS) 1'h0;
    end
    else if (!ce_n_in && cle_in && dq_in == 8'h70)
      id_mode = 1'h0;
    else if (!ce_n_in && cle_in && !busy && dq_in == 8'h90)
      id_mode = 1'h1;
    else if (!ce_n_in && ale_in)
      idx = 3'h0;
  end
  always_comb
    case (idx)
      3'h0:    cur = id_mode ? MAKER : stat;
      3'h1:    cur = id_mode ? DEVICE : stat;
      3'h2:    cur = id_mode ? id3_in : stat;
      3'h3:    cur = id_mode ? id4_in : stat;
      default: cur = id_mode ? id5_in : stat;
    endcase
  always @(posedge read_strobe_n_in)
  begin
    last = cur;
    if (!ce_n_in && id_mode && idx < 3'h4)
      idx = idx + 3'h1;
  end
  // released port shows the inverse of the last byte
  assign dq_out = (!ce_n_in && !read_strobe_n_in) ? cur : ~last;
endmodule : nand_dev_model
`default_nettype wire

// ==== verif/tb_nand_ctl.sv ====
// self-checking bench of the nand controller against the device model
`timescale 1ns/10ps
`default_nettype none
`include "nand_ctl_map.svh"
module tb_nand_ctl;
  logic        ref_clk = 1'h0;
  logic        rstn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cle, ale, ce_n, we_n, re_n, wp_n, oe, rb;
  logic [7:0]  port_o, port_i, dev_dq;
  logic [7:0]  id3 = 8'h00, id4 = 8'h00, id5 = 8'h00, lfsr = 8'h27;
  logic [7:0]  exp_q[$];
  logic [31:0] r;
  logic        e;
  int          failures = 0;
  int          comparisons = 0;
  //////////////////////////////////////////////////////////////////////////////
  always #4 ref_clk = ~ref_clk;
  assign port_i = oe ? port_o : dev_dq;
  nand_ctl u_nand_ctl (.ref_clk_in(ref_clk), .rstn_in(rstn), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cmd_latch_out(cle),
    .addr_latch_out(ale), .chip_en_n_out(ce_n), .write_strobe_n_out(we_n),
    .read_strobe_n_out(re_n), .write_prot_n_out(wp_n), .shared_byte_port_out(port_o),
    .shared_byte_port_oe_out(oe), .shared_byte_port_in(port_i), .ready_busy_n_pin_in(rb));
  nand_dev_model u_nand_dev_model (.cle_in(cle), .ale_in(ale), .ce_n_in(ce_n), .we_n_in(we_n),
    .read_strobe_n_in(re_n), .wp_n_in(wp_n), .dq_in(port_i), .id3_in(id3), .id4_in(id4),
    .id5_in(id5), .dq_out(dev_dq), .ready_busy_n_pin_out(rb));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task automatic stop_test;
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
      @(posedge ref_clk);
    while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask : apb
  task automatic run_op(input logic [2:0] op, input logic wp, input logic err);
    int n;
    n = 0;
    apb(1'h1, `OFS_CTRL, {27'h0, wp, op, 1'h1});
    do
      begin
        apb(1'h0, `OFS_STAT, 32'h0);
        n++;
      end
    while (r[0] !== 1'h1 && n < 300);
    chk({31'h0, r[0]}, 32'h1, "op finished");
    chk({31'h0, r[5]}, {31'h0, err}, "op error flag");
  endtask : run_op
  task automatic wait_ready;
    int n;
    n = 0;
    do
      begin
        apb(1'h0, `OFS_STAT, 32'h0);
        n++;
      end
    while (r[2] !== 1'h1 && n < 2000);
    chk({31'h0, r[2]}, 32'h1, "device ready");
  endtask : wait_ready
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #300000;
    failures++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'h1;
    run_op(`OP_ID, 1'h0, 1'h1);
    run_op(`OP_STATUS, 1'h0, 1'h0);
    apb(1'h0, `OFS_DATA, 32'h0);
    chk(r & 32'hff, 32'h00, "status while busy");
    chk({31'h0, wp_n}, 32'h0, "protect pin");
    run_op(`OP_RESET, 1'h0, 1'h0);
    wait_ready;
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      id3 <= {lfsr[7:4], i[1:0], i[1:0]};
      id4 <= {lfsr[7:6], i[1:0], lfsr[3:2], i[1:0]};
      id5 <= {lfsr[7:4], i[1:0], lfsr[1:0]};
      run_op(`OP_STATUS, lfsr[1], 1'h0);
      apb(1'h0, `OFS_DATA, 32'h0);
      chk(r & 32'hff, {24'h0, lfsr[1], 7'h20}, "status byte");
      chk({31'h0, wp_n}, {31'h0, lfsr[1]}, "protect pin");
      exp_q = {8'h5a, 8'h3c, id3, id4, id5};
      run_op(`OP_ID, lfsr[1], 1'h0);
      apb(1'h0, `OFS_ID_LO, 32'h0);
      chk(r, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]}, "id bytes 1-4");
      apb(1'h0, `OFS_ID_HI, 32'h0);
      chk(r & 32'hff, {24'h0, exp_q[4]}, "id byte 5");
    end
    apb(1'h1, `OFS_CTRL, {27'h1, `OP_STATUS, 1'h1});
    run_op(`OP_ID, 1'h1, 1'h1);
    apb(1'h0, 12'h100, 32'h0);
    chk({e, r[30:0]}, 32'h80000000, "unmapped access");
    run_op(3'h5, 1'h1, 1'h1);
    run_op(`OP_READ_RESUME, 1'h1, 1'h0);
    run_op(`OP_STATUS, 1'h1, 1'h0);
    apb(1'h0, `OFS_DATA, 32'h0);
    chk(r & 32'hff, 32'ha0, "status after resume");
    stop_test;
  end
endmodule : tb_nand_ctl
`default_nettype wire
